// File: hw/ddrlf_transceiver.sv
// ddr link fifo transceiver: transmit fifo, serialiser, receiver and receive fifo
`timescale 1ns/1ps
module ddrlf_transceiver #(
    parameter int DATA_W    = ddrlf_pkg::DATA_W,
    parameter int LANE_W    = ddrlf_pkg::LANE_W,
    parameter int TX_DEPTH  = ddrlf_pkg::TX_DEPTH,
    parameter int RX_DEPTH  = ddrlf_pkg::RX_DEPTH,
    parameter bit PARITY_EN = 1'b1
) (
    // system
    input  wire logic                                clk_sys,
    input  wire logic                                reset,
    // transmit user port
    input  wire logic                                link_tx_reset,
    input  wire logic                                link_source_clock,
    input  wire logic                                user_write_clock,
    input  wire logic                                tx_write_request,
    input  wire logic [DATA_W-1:0]                   tx_write_data,
    input  wire logic [DATA_W/ddrlf_pkg::BYTE_W-1:0] tx_write_parity,
    output logic                                     tx_fifo_full,
    // outgoing link
    output logic                                     tx_forwarded_link_clock,
    output logic                                     tx_parcel_valid_flag,
    output logic [LANE_W-1:0]                        tx_ddr_link_lanes,
    output logic [LANE_W/ddrlf_pkg::BYTE_W-1:0]      tx_link_parity,
    output logic                                     tx_far_receiver_reset,
    input  wire logic                                tx_almost_full_return,
    // incoming link
    input  wire logic                                rx_forwarded_link_clock,
    input  wire logic                                rx_parcel_valid_flag,
    input  wire logic [LANE_W-1:0]                   rx_ddr_link_lanes,
    input  wire logic [LANE_W/ddrlf_pkg::BYTE_W-1:0] rx_link_parity,
    input  wire logic                                rx_far_receiver_reset,
    output logic                                     rx_almost_full_return,
    // receive user port
    input  wire logic                                user_read_clock,
    input  wire logic                                rx_read_request,
    output logic                                     rx_fifo_empty,
    output logic [DATA_W-1:0]                        rx_read_data,
    output logic [DATA_W/ddrlf_pkg::BYTE_W-1:0]      rx_read_parity
);
    localparam int PAR_W   = DATA_W / ddrlf_pkg::BYTE_W;
    localparam int LPAR_W  = LANE_W / ddrlf_pkg::BYTE_W;
    localparam int WORD_W  = DATA_W + PAR_W;
    localparam int PCL_W   = LANE_W + LPAR_W;
    localparam int PARCELS = DATA_W / LANE_W;
    localparam int PI_W    = $clog2(PARCELS + 1);
    localparam int TA_W    = $clog2(TX_DEPTH);
    localparam int RA_W    = $clog2(RX_DEPTH);
    localparam int CTL_N   = 10;
    localparam int SW      = CTL_N + PCL_W + DATA_W + PAR_W;
    localparam logic [TA_W:0] TX_FULL_THR = (TA_W+1)'(TX_DEPTH - TX_DEPTH / ddrlf_pkg::FULL_DIV);
    localparam logic [RA_W:0] RX_AF_THR   = (RA_W+1)'(RX_DEPTH - RX_DEPTH / ddrlf_pkg::FULL_DIV);
    localparam logic [RA_W:0] RX_CAP      = (RA_W+1)'(RX_DEPTH);
    localparam logic [PI_W-1:0] PI_STEP   = PI_W'(ddrlf_pkg::PARCEL_STEP);
    localparam logic [PI_W-1:0] PI_LAST   = PI_W'(PARCELS);
    localparam logic [ddrlf_pkg::INIT_W-1:0] TX_INIT_LAST = ddrlf_pkg::INIT_W'(ddrlf_pkg::TX_INIT_CYC - 1);
    localparam logic [ddrlf_pkg::INIT_W-1:0] RX_INIT_LAST = ddrlf_pkg::INIT_W'(ddrlf_pkg::RX_INIT_CYC - 1);

    typedef struct packed {
        logic [SW-1:0]                    s1;
        logic [SW-1:0]                    s2;
        logic                             wclk_p;
        logic                             rclk_p;
        logic                             src_p;
        logic                             lclk_p;
        logic                             lrise_p;
        logic [PCL_W-1:0]                 lane_p;
        ddrlf_pkg::ddrlf_link_st_t        tx_st;
        logic [ddrlf_pkg::INIT_W-1:0]     tx_init;
        logic [TA_W:0]                    tx_cnt;
        logic [TA_W-1:0]                  tx_wp;
        logic [TA_W-1:0]                  tx_rp;
        logic [1:0][WORD_W-1:0]           skid;
        logic [1:0]                       skid_n;
        logic [WORD_W-1:0]                shreg;
        logic [PI_W-1:0]                  tx_pidx;
        logic                             tx_busy;
        logic                             full;
        ddrlf_pkg::ddrlf_link_ctl_t       ctl;
        logic [PCL_W-1:0]                 tx_lane;
        ddrlf_pkg::ddrlf_link_st_t        rx_st;
        logic [ddrlf_pkg::INIT_W-1:0]     rx_init;
        logic [RA_W:0]                    rx_cnt;
        logic [RA_W-1:0]                  rx_wp;
        logic [RA_W-1:0]                  rx_rp;
        logic                             pend_flag;
        logic [PCL_W-1:0]                 pend_p0;
        logic [WORD_W-1:0]                acc;
        logic [PI_W-1:0]                  rx_pidx;
        logic                             empty;
        logic                             af_out;
        logic [WORD_W-1:0]                rdata;
    } ddrlf_state_t;

    ddrlf_state_t      q;
    ddrlf_state_t      n;
    logic [WORD_W-1:0] tx_mem [TX_DEPTH];
    logic [WORD_W-1:0] rx_mem [RX_DEPTH];
    logic [WORD_W-1:0] tx_head;
    logic [WORD_W-1:0] rx_head;
    logic              tx_we;
    logic [WORD_W-1:0] tx_wd;
    logic              rx_we;
    logic [WORD_W-1:0] rx_wd;
    logic [SW-1:0]     async_in;
    logic              flag_s, lclk_s, frr_s, af_s, src_s, rreq_s, rclk_s, wreq_s, wclk_s, txrst_s;
    logic [PCL_W-1:0]  lane_s;
    logic [PAR_W-1:0]  wpar_s;
    logic [DATA_W-1:0] wdata_s;
    logic              w_edge, r_edge, s_rise, s_fall, l_rise;
    logic              wr_take, buf_push, ser_take, rd_take, rx_push;

    function automatic logic [PCL_W-1:0] parcel(input logic [WORD_W-1:0] w, input logic [PI_W-1:0] i);
        parcel = {w[DATA_W + int'(i) * LPAR_W +: LPAR_W], w[int'(i) * LANE_W +: LANE_W]};
    endfunction

    // slow control lines and all foreign-domain inputs: two flops before use
    assign async_in = {tx_write_data, tx_write_parity, rx_link_parity, rx_ddr_link_lanes, link_tx_reset,
                       user_write_clock, tx_write_request, user_read_clock, rx_read_request, link_source_clock,
                       tx_almost_full_return, rx_far_receiver_reset, rx_forwarded_link_clock, rx_parcel_valid_flag};
    assign flag_s  = q.s2[0];
    assign lclk_s  = q.s2[1];
    assign frr_s   = q.s2[2];
    assign af_s    = q.s2[3];
    assign src_s   = q.s2[4];
    assign rreq_s  = q.s2[5];
    assign rclk_s  = q.s2[6];
    assign wreq_s  = q.s2[7];
    assign wclk_s  = q.s2[8];
    assign txrst_s = q.s2[9];
    assign lane_s  = {q.s2[CTL_N + LANE_W +: LPAR_W], q.s2[CTL_N +: LANE_W]};
    assign wpar_s  = PARITY_EN ? q.s2[CTL_N + PCL_W +: PAR_W] : '0;
    assign wdata_s = q.s2[CTL_N + PCL_W + PAR_W +: DATA_W];
    assign tx_head = tx_mem[q.tx_rp];
    assign rx_head = rx_mem[q.rx_rp];

    // user clocks are sampled and only their rising edges act
    assign w_edge = wclk_s & ~q.wclk_p;
    assign r_edge = rclk_s & ~q.rclk_p;
    // forwarded clock follows the synchronised source clock, both edges used
    assign s_rise = src_s & ~q.src_p;
    assign s_fall = ~src_s & q.src_p;
    // the receiver acts on the incoming rising edge only
    assign l_rise = lclk_s & ~q.lclk_p;

    // take a word only on a write edge with full low
    assign wr_take  = w_edge & wreq_s & ~q.full & (q.tx_st == ddrlf_pkg::LS_RUN);
    assign buf_push = (q.tx_cnt != '0) & (q.skid_n != 2'h2) & (q.tx_st == ddrlf_pkg::LS_RUN);
    // no new word starts while the far receiver reports almost full
    assign ser_take = s_rise & ~q.tx_busy & (q.skid_n != 2'h0) & ~af_s & (q.tx_st == ddrlf_pkg::LS_RUN);
    // read only on a read edge with empty low
    assign rd_take  = r_edge & rreq_s & ~q.empty;
    assign rx_push  = l_rise & q.pend_flag & (q.rx_st == ddrlf_pkg::LS_RUN) & (q.rx_pidx + PI_STEP == PI_LAST)
                      & (q.rx_cnt < RX_CAP);

    always_comb begin
        n        = q;
        n.s1     = async_in;
        n.s2     = q.s1;
        n.wclk_p = wclk_s;
        n.rclk_p = rclk_s;
        n.src_p  = src_s;
        n.lclk_p = lclk_s;
        n.lrise_p = l_rise;
        n.lane_p = lane_s;
        tx_we    = wr_take;
        tx_wd    = {wpar_s, wdata_s};
        rx_we    = 1'b0;
        rx_wd    = '0;

        case (q.tx_st)
            ddrlf_pkg::LS_RESET: begin
                n.tx_st   = ddrlf_pkg::LS_INIT;
                n.tx_init = '0;
            end
            ddrlf_pkg::LS_INIT: begin
                n.tx_init = q.tx_init + 12'h001;
                if (q.tx_init == TX_INIT_LAST) begin
                    n.tx_st = ddrlf_pkg::LS_RUN;
                end
            end
            ddrlf_pkg::LS_RUN: begin
                n.tx_st = ddrlf_pkg::LS_RUN;
            end
            default: begin
                n.tx_st = ddrlf_pkg::LS_RESET;
            end
        endcase

        if (wr_take) begin
            n.tx_wp = q.tx_wp + TA_W'(1);
        end
        if (buf_push) begin
            n.tx_rp = q.tx_rp + TA_W'(1);
        end
        n.tx_cnt = q.tx_cnt + (TA_W+1)'(wr_take) - (TA_W+1)'(buf_push);

        // two-entry buffer between the fifo and the serialiser
        n.skid_n = q.skid_n - 2'(ser_take);
        if (ser_take) begin
            n.skid[0] = q.skid[1];
        end
        if (buf_push) begin
            n.skid[n.skid_n[0]] = tx_head;
            n.skid_n = n.skid_n + 2'h1;
        end

        // high phase carries the even parcel, low phase the odd one
        if (s_rise) begin
            n.ctl.fwd_clk = 1'b1;
            if (q.tx_busy) begin
                n.tx_lane        = parcel(q.shreg, q.tx_pidx);
                n.ctl.valid_flag = 1'b1;
            end else if (ser_take) begin
                n.shreg          = q.skid[0];
                n.tx_pidx        = '0;
                n.tx_busy        = 1'b1;
                n.tx_lane        = parcel(q.skid[0], '0);
                n.ctl.valid_flag = 1'b1;
            end else begin
                n.ctl.valid_flag = 1'b0;
            end
        end
        if (s_fall) begin
            n.ctl.fwd_clk = 1'b0;
            if (q.tx_busy) begin
                n.tx_lane = parcel(q.shreg, q.tx_pidx + PI_W'(1));
                n.tx_pidx = q.tx_pidx + PI_STEP;
                if (q.tx_pidx + PI_STEP == PI_LAST) begin
                    n.tx_busy = 1'b0;
                end
            end
        end

        // transmit reset clears the whole path and resets the far end
        if (txrst_s) begin
            n.tx_st          = ddrlf_pkg::LS_RESET;
            n.tx_cnt         = '0;
            n.tx_wp          = '0;
            n.tx_rp          = '0;
            n.skid_n         = 2'h0;
            n.tx_busy        = 1'b0;
            n.ctl.valid_flag = 1'b0;
            tx_we            = 1'b0;
        end
        n.ctl.far_rst = (n.tx_st == ddrlf_pkg::LS_RESET);
        // full held during reset and init, then from the almost-full threshold
        n.full = (n.tx_st != ddrlf_pkg::LS_RUN) | (n.tx_cnt >= TX_FULL_THR);

        // receive side sequencing
        case (q.rx_st)
            ddrlf_pkg::LS_RESET: begin
                n.rx_st   = ddrlf_pkg::LS_INIT;
                n.rx_init = '0;
            end
            ddrlf_pkg::LS_INIT: begin
                n.rx_init = q.rx_init + 12'h001;
                if (q.rx_init == RX_INIT_LAST) begin
                    n.rx_st = ddrlf_pkg::LS_RUN;
                end
            end
            ddrlf_pkg::LS_RUN: begin
                n.rx_st = ddrlf_pkg::LS_RUN;
            end
            default: begin
                n.rx_st = ddrlf_pkg::LS_RESET;
            end
        endcase

        // at each rising edge close the pair begun one period earlier
        if (l_rise && q.pend_flag && q.rx_st == ddrlf_pkg::LS_RUN) begin
            n.acc[int'(q.rx_pidx) * LANE_W +: LANE_W]                = q.pend_p0[LANE_W-1:0];
            n.acc[DATA_W + int'(q.rx_pidx) * LPAR_W +: LPAR_W]       = q.pend_p0[LANE_W +: LPAR_W];
            n.acc[(int'(q.rx_pidx) + 1) * LANE_W +: LANE_W]          = q.lane_p[LANE_W-1:0];
            n.acc[DATA_W + (int'(q.rx_pidx) + 1) * LPAR_W +: LPAR_W] = q.lane_p[LANE_W +: LPAR_W];
            n.rx_pidx = (q.rx_pidx + PI_STEP == PI_LAST) ? '0 : q.rx_pidx + PI_STEP;
        end
        // high-phase parcel taken one cycle after the edge for margin against lane skew
        if (q.lrise_p) begin
            n.pend_flag = flag_s & (q.rx_st == ddrlf_pkg::LS_RUN);
            n.pend_p0   = lane_s;
        end
        if (rx_push) begin
            rx_we   = 1'b1;
            rx_wd   = n.acc;
            n.rx_wp = q.rx_wp + RA_W'(1);
        end
        // next word loads on an accepted read and then holds
        if (rd_take) begin
            n.rdata = PARITY_EN ? rx_head : {{PAR_W{1'b0}}, rx_head[DATA_W-1:0]};
            n.rx_rp = q.rx_rp + RA_W'(1);
        end
        n.rx_cnt = q.rx_cnt + (RA_W+1)'(rx_push) - (RA_W+1)'(rd_take);

        if (frr_s) begin
            n.rx_st     = ddrlf_pkg::LS_RESET;
            n.rx_cnt    = '0;
            n.rx_wp     = '0;
            n.rx_rp     = '0;
            n.rx_pidx   = '0;
            n.pend_flag = 1'b0;
            rx_we       = 1'b0;
        end
        // empty until running and a word is stored
        n.empty  = (n.rx_st != ddrlf_pkg::LS_RUN) | (n.rx_cnt == '0);
        // almost-full also held while not running, so nothing is sent too early
        n.af_out = (n.rx_st != ddrlf_pkg::LS_RUN) | (n.rx_cnt >= RX_AF_THR);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            q             <= '0;
            q.full        <= 1'b1;
            q.ctl.far_rst <= 1'b1;
            q.empty       <= 1'b1;
            q.af_out      <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // fifo storage carries no reset
    always_ff @(posedge clk_sys) begin
        if (tx_we) begin
            tx_mem[q.tx_wp] <= tx_wd;
        end
        if (rx_we) begin
            rx_mem[q.rx_wp] <= rx_wd;
        end
    end

    // ports come straight from state flops
    assign tx_fifo_full            = q.full;
    assign tx_forwarded_link_clock = q.ctl.fwd_clk;
    assign tx_parcel_valid_flag    = q.ctl.valid_flag;
    assign tx_ddr_link_lanes       = q.tx_lane[LANE_W-1:0];
    assign tx_link_parity          = q.tx_lane[LANE_W +: LPAR_W];
    assign tx_far_receiver_reset   = q.ctl.far_rst;
    assign rx_almost_full_return   = q.af_out;
    assign rx_fifo_empty           = q.empty;
    assign rx_read_data            = q.rdata[DATA_W-1:0];
    assign rx_read_parity          = q.rdata[DATA_W +: PAR_W];

    // one wrapper, latency set by link periods through both fifos
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_read_taken;
        r_edge && rreq_s && !q.empty;
    endsequence
    sequence s_fall_mid_word;
        s_fall && q.tx_busy && !txrst_s;
    endsequence

    a_full_during_reset: assert property (txrst_s |=> tx_fifo_full ##1 tx_fifo_full)
        else $error("full not held during transmit reset");
    a_far_reset_out: assert property (txrst_s |=> tx_far_receiver_reset)
        else $error("far receiver reset not driven");
    a_write_counted: assert property (wr_take && !buf_push && !txrst_s |=> q.tx_cnt == $past(q.tx_cnt) + 1)
        else $error("accepted write not stored");
    a_write_refused: assert property (w_edge && wreq_s && q.full && !buf_push && !txrst_s |=> $stable(q.tx_cnt))
        else $error("write taken while full");
    a_empty_on_reset: assert property (frr_s |=> rx_fifo_empty)
        else $error("empty low during channel reset");
    a_read_loads: assert property (s_read_taken |=> rx_read_data == $past(rx_head[DATA_W-1:0]))
        else $error("read data not loaded from fifo head");
    a_read_refused: assert property (r_edge && rreq_s && q.empty |=> $stable(rx_read_data))
        else $error("read data changed on refused read");
    a_af_threshold: assert property (q.rx_cnt >= RX_AF_THR |-> rx_almost_full_return)
        else $error("almost full not raised at threshold");
    a_stall_on_af: assert property (af_s && s_rise && !q.tx_busy |=> !tx_parcel_valid_flag)
        else $error("parcel sent while far end almost full");
    a_flag_spans_low: assert property ($fell(tx_forwarded_link_clock) && !$past(txrst_s)
                                       |-> tx_parcel_valid_flag == $past(tx_parcel_valid_flag))
        else $error("valid flag changed at falling edge");
    a_two_parcels: assert property (s_fall_mid_word |=> q.tx_pidx == $past(q.tx_pidx) + PI_STEP)
        else $error("parcel index did not advance by two");
    // synchroniser still holds reset values for two cycles after release
    a_sync_depth: assert property (!$past(reset) && !$past(reset, 2)
                                   |-> frr_s == $past(rx_far_receiver_reset, 2))
        else $error("far reset not passed through two stages");

endmodule // ddrlf_transceiver

// File: hw/ddrlf_pkg.sv
// constants and shared types for the ddr link fifo channel
//Behaviour
// - transmit reset holds the full flag high until the channel is initialised.
// - transmit reset resets the whole channel and drives the far receiver reset line.
// - a word is taken at a write clock rising edge with request high and full low.
// - write requests made while full is high are ignored.
// - data width is a parameter; with parity it must be a multiple of 8.
// - one parity bit per 8 data bits, sampled like the write data.
// - empty goes high on channel reset and stays high until init and first word.
// - a read is taken at a read clock rising edge with request high and empty low.
// - after a read the next word appears on read data and holds until the next read.
// - read requests made while empty is high are ignored.
// - read data and parity widths equal the transmit widths and share timing.
// - one word per write clock and per read clock while flags allow.
// - two parcels per forwarded clock period on every lane.
// - far reset and almost-full return are slow asynchronous lines, not link data.
// - transmit signals follow the write clock, receive signals the read clock.
// - the link source clock generates the forwarded link clock.
// - transceiver holds transmitter and receiver paths.
// - latency counts link clock periods from write to availability at the read port.
// - valid flag high in the high phase marks data in that phase and the next.
// - words split into lane-wide parcels and reassembled at the receiver.
// - lanes change on both forwarded clock edges; receiver uses only the rising edge.
// - full and almost-full return derive from thresholds at seven eighths of depth; empty from a zero count or the receiver not running.
package ddrlf_pkg;
    localparam int DATA_W       = 16;
    localparam int LANE_W       = 8;
    localparam int BYTE_W       = 8;
    localparam int TX_DEPTH     = 32;
    localparam int RX_DEPTH     = 32;
    localparam int FULL_DIV     = 8;
    localparam int PARCEL_STEP  = 2;
    localparam int CLK_MHZ      = 200;
    localparam int TX_INIT_NS   = 2000;
    localparam int RX_INIT_NS   = 1000;
    localparam int TX_INIT_CYC  = (TX_INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int RX_INIT_CYC  = (RX_INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_W       = 12;

    typedef enum logic [1:0] {
        LS_RESET = 2'b00,
        LS_INIT  = 2'b01,
        LS_RUN   = 2'b10
    } ddrlf_link_st_t;

    typedef struct packed {
        logic fwd_clk;
        logic valid_flag;
        logic far_rst;
    } ddrlf_link_ctl_t;
endpackage

// File: testbench/ddrlf_link_partner.sv
// far-end model: this device's outgoing link lines, delayed and wired straight back into it
`timescale 1ns/1ps
module ddrlf_link_partner (
    // lines leaving the device
    input  wire logic                                fwd_clk_in,
    input  wire logic                                flag_in,
    input  wire logic [ddrlf_pkg::LANE_W-1:0]        lanes_in,
    input  wire logic [ddrlf_pkg::LANE_W/8-1:0]      par_in,
    input  wire logic                                far_rst_in,
    input  wire logic                                af_in,
    // lines entering the device
    output logic                                     fwd_clk_out,
    output logic                                     flag_out,
    output logic [ddrlf_pkg::LANE_W-1:0]             lanes_out,
    output logic [ddrlf_pkg::LANE_W/8-1:0]           par_out,
    output logic                                     far_rst_out,
    output logic                                     af_out
);
    // equal flight time keeps clock, flag and lanes aligned
    assign #2 fwd_clk_out = fwd_clk_in;
    assign #2 flag_out    = flag_in;
    assign #2 lanes_out   = lanes_in;
    assign #2 par_out     = par_in;
    // slow control lines, skewed on purpose against the clock domain
    assign #13 far_rst_out = far_rst_in;
    assign #17 af_out      = af_in;
endmodule // ddrlf_link_partner

// File: testbench/ddrlf_transceiver_test.sv
// self-checking bench: transceiver looped through a far-end model
`timescale 1ns/1ps
module ddrlf_transceiver_test;
    logic        clk_sys = 0, reset = 1, link_tx_reset = 0, link_source_clock = 0;
    logic        user_write_clock = 0, user_read_clock = 0, tx_write_request = 0, rx_read_request = 0;
    logic [15:0] tx_write_data = 16'h0000, rx_read_data;
    logic [1:0]  tx_write_parity = 2'h0, rx_read_parity;
    logic        tx_fifo_full, rx_fifo_empty, t_clk, t_flag, t_rst, t_af, r_clk, r_flag, r_rst, r_af;
    logic [7:0]  t_lanes, r_lanes;
    logic [0:0]  t_par, r_par;
    int          wcnt = 0, rcnt = 0, scnt = 11, seq = 0, error_cnt = 0, checks = 0;
    logic [17:0] wq[$];

    ddrlf_transceiver i_dut (.clk_sys(clk_sys), .reset(reset), .link_tx_reset(link_tx_reset),
        .link_source_clock(link_source_clock), .user_write_clock(user_write_clock),
        .tx_write_request(tx_write_request), .tx_write_data(tx_write_data), .tx_write_parity(tx_write_parity),
        .tx_fifo_full(tx_fifo_full), .tx_forwarded_link_clock(t_clk), .tx_parcel_valid_flag(t_flag),
        .tx_ddr_link_lanes(t_lanes), .tx_link_parity(t_par), .tx_far_receiver_reset(t_rst),
        .tx_almost_full_return(r_af), .rx_forwarded_link_clock(r_clk), .rx_parcel_valid_flag(r_flag),
        .rx_ddr_link_lanes(r_lanes), .rx_link_parity(r_par), .rx_far_receiver_reset(r_rst),
        .rx_almost_full_return(t_af), .user_read_clock(user_read_clock), .rx_read_request(rx_read_request),
        .rx_fifo_empty(rx_fifo_empty), .rx_read_data(rx_read_data), .rx_read_parity(rx_read_parity));
    ddrlf_link_partner i_far (.fwd_clk_in(t_clk), .flag_in(t_flag), .lanes_in(t_lanes), .par_in(t_par),
        .far_rst_in(t_rst), .af_in(t_af), .fwd_clk_out(r_clk), .flag_out(r_flag), .lanes_out(r_lanes),
        .par_out(r_par), .far_rst_out(r_rst), .af_out(r_af));

    always #2.5 clk_sys = ~clk_sys;
    // user clocks 40 ns and 50 ns, link source 160 ns, all from the system clock's edges
    always @(posedge clk_sys) begin
        wcnt <= (wcnt + 1) % 8;
        rcnt <= (rcnt + 1) % 10;
        scnt <= (scnt + 1) % 32;
        user_write_clock <= (wcnt < 4);
        user_read_clock <= (rcnt < 5);
        link_source_clock <= (scnt < 16);
    end

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        for (n = 0; n < 3000 && tx_fifo_full !== 1'b0; n++) @(posedge clk_sys);
        if (n == 3000) begin
            check("full flag cleared", tx_fifo_full, 18'h0);
            end_sim();
        end
    endtask

    // writes nw words when full allows, reads when empty allows; requests held a whole user clock period
    task automatic xfer(input int nw, input bit rd_on, input int cyc);
        bit          pend = 0, idle = 0, wdone = 0, rdone = 0;
        logic [17:0] last = 18'h00000;
        for (int c = 0; !(wdone && rdone); c++) begin
            @(posedge clk_sys);
            if (wcnt == 6 && !wdone) begin
                wdone = (c >= cyc);
                tx_write_request <= (nw > 0) && !wdone;
                tx_write_data <= 16'ha500 + seq[15:0];
                tx_write_parity <= seq[1:0];
            end
            // judged on full as the design sees it, three cycles after the write clock rises
            if (wcnt == 3 && tx_write_request && tx_fifo_full === 1'b0) begin
                wq.push_back({tx_write_parity, tx_write_data});
                seq++;
                nw--;
            end
            if (rcnt == 8 && !rdone) begin
                // read returns the oldest word and its side bits
                if (pend) check("read word", {rx_read_parity, rx_read_data}, wq.pop_front());
                // refused read leaves the output alone
                if (idle) check("held word", {rx_read_parity, rx_read_data}, last);
                rdone = (c >= cyc);
                last = {rx_read_parity, rx_read_data};
                pend = rd_on && !rdone && rx_fifo_empty === 1'b0;
                idle = rd_on && !rdone && rx_fifo_empty === 1'b1 && wq.size() == 0;
                rx_read_request <= pend || idle;
            end
        end
    endtask

    task automatic test_reset();
        check("full in reset", tx_fifo_full, 18'h1);
        check("far reset in reset", t_rst, 18'h1);
        reset <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check("full during init", tx_fifo_full, 18'h1);
        check("empty during init", rx_fifo_empty, 18'h1);
        wait_ready();
        check("empty with no word", rx_fifo_empty, 18'h1);
        $display("test reset done");
    endtask

    task automatic test_stream();
        xfer(12, 1, 700);
        check("words left", 18'(wq.size()), 18'h0);
        $display("test stream done");
    endtask

    task automatic test_fill();
        xfer(80, 0, 1200);
        check("full when stalled", tx_fifo_full, 18'h1);
        // stall back-pressures without loss, both fifos usable to seven eighths
        check("stored words", 18'(wq.size() >= 2 * (ddrlf_pkg::TX_DEPTH - ddrlf_pkg::TX_DEPTH / 8)), 18'h1);
        xfer(0, 1, 1600);
        check("words after drain", 18'(wq.size()), 18'h0);
        $display("test fill done");
    endtask

    task automatic test_chan_reset();
        link_tx_reset <= 1'b1;
        repeat (10) @(posedge clk_sys);
        check("full in channel reset", tx_fifo_full, 18'h1);
        check("far reset driven", t_rst, 18'h1);
        repeat (20) @(posedge clk_sys);
        check("far empty in reset", rx_fifo_empty, 18'h1);
        link_tx_reset <= 1'b0;
        wait_ready();
        xfer(4, 1, 400);
        check("words after restart", 18'(wq.size()), 18'h0);
        $display("test channel reset done");
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        test_reset();
        test_stream();
        test_fill();
        test_chan_reset();
        end_sim();
    end
endmodule // ddrlf_transceiver_test
